// ===== testbench.sv
// self-checking bench for the interrupt acceptance core
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // stimulus side
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] reg_addr_i = '0;
  logic [31:0] reg_wdata_i = '0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [15:0] src_evt_i = '0;
  logic [15:0] src_clr_i = '0;
  logic nmi_evt_i = 1'b0;
  logic [23:0] cpu_pc_i = '0;
  logic [3:0] done_dly = '0;
  // observed side
  logic [31:0] reg_rdata_o, stk_data_o, vec_data_i, jump_addr_o;
  logic cpu_insn_done_i, stk_we_o, vec_rd_o, vec_ack_i, jump_o, busy_o;
  logic [15:0] vec_addr_o;
  int err_count = 0;
  int total_checks = 0;
  always #10 sys_clk_i = ~sys_clk_i;
  tmia_core DUT (.sys_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .src_evt_i, .src_clr_i, .nmi_evt_i,
    .cpu_insn_done_i, .cpu_pc_i, .stk_we_o, .stk_data_o, .vec_rd_o,
    .vec_addr_o, .vec_ack_i, .vec_data_i, .jump_o, .jump_addr_o, .busy_o);
  tmia_cpu_model cpu (.sys_clk_i, .srst_i, .busy_i(busy_o), .vec_rd_i(vec_rd_o),
    .vec_addr_i(vec_addr_o), .done_dly_i(done_dly), .insn_done_o(cpu_insn_done_i),
    .vec_ack_o(vec_ack_i), .vec_data_o(vec_data_i));
  ////////////////////////////////////////////////////////////////
  // compare, verdict and hang cut-off
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic expire();
    err_count++;
    $display("Error at %0t: wait expired", $time);
    final_report();
  endtask
  ////////////////////////////////////////////////////////////////
  // register port and source pulses
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    chk(reg_rdata_o, e);
  endtask
  task automatic pulse(input logic [15:0] v, input logic n);
    @(posedge sys_clk_i);
    src_evt_i <= v;
    nmi_evt_i <= n;
    @(posedge sys_clk_i);
    src_evt_i <= '0;
    nmi_evt_i <= 1'b0;
  endtask
  // core must stay idle for a while
  task automatic quiet();
    logic seen;
    seen = 1'b0;
    repeat (8) begin
      @(negedge sys_clk_i);
      seen = seen | (busy_o !== 1'b0);
    end
    chk({31'h0, seen}, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////
  // follow one acceptance from busy to jump
  task automatic accept(input int vec, input int prio, input logic [3:0] dly,
    input logic [31:0] ccr_s, input logic [31:0] exr_s, input int nw);
    int n;
    logic [31:0] w[$];
    cpu_pc_i <= 24'h00a000 + vec[23:0];
    done_dly <= dly;
    n = 0;
    @(negedge sys_clk_i);
    while (busy_o !== 1'b1) begin
      @(negedge sys_clk_i);
      n++;
      if (n > 60) expire();
    end
    n = 0;
    while (stk_we_o !== 1'b1) begin
      @(negedge sys_clk_i);
      n++;
      if (n > 60) expire();
    end
    chk(n, ((int'(dly) > prio) ? int'(dly) : prio) + 1);
    while (stk_we_o === 1'b1 && w.size() < 4) begin
      w.push_back(stk_data_o);
      @(negedge sys_clk_i);
    end
    chk(w.size(), nw);
    chk(w[0], 32'h00a000 + vec);
    chk(w[1], ccr_s);
    if (nw == 3) chk(w[2], exr_s);
    n = 0;
    while (vec_rd_o !== 1'b1) begin
      @(negedge sys_clk_i);
      n++;
      if (n > 20) expire();
    end
    chk({16'h0, vec_addr_o}, vec * 4);
    while (jump_o !== 1'b1) begin
      @(negedge sys_clk_i);
      n++;
      if (n > 40) expire();
    end
    chk(jump_addr_o, {16'h5a00, 16'(vec * 4)});
  endtask
  ////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    rdc(tmia_pkg::OFS_CCR, 32'h80);
    rdc(tmia_pkg::OFS_EXR, 32'h07);
    wr(tmia_pkg::OFS_MODE, 32'h1);
    rdc(tmia_pkg::OFS_MODE, 32'h0);
    rdc(8'h20, 32'h0);
  endtask
  task automatic t_m0_mask();
    wr(tmia_pkg::OFS_EN, 32'h8);
    pulse(16'h0028, 1'b0);
    quiet();
    rdc(tmia_pkg::OFS_PEND, 32'h8);
    pulse(16'h0, 1'b1);
    accept(7, 3, 4'h0, 32'h80, 32'h0, 2);
    rdc(tmia_pkg::OFS_PEND, 32'h8);
    @(posedge sys_clk_i);
    src_clr_i <= 16'h8;
    @(posedge sys_clk_i);
    src_clr_i <= '0;
    rdc(tmia_pkg::OFS_PEND, 32'h0);
  endtask
  task automatic t_m0_order();
    wr(tmia_pkg::OFS_EN, 32'h0204);
    pulse(16'h0204, 1'b0);
    quiet();
    wr(tmia_pkg::OFS_CCR, 32'h0);
    accept(66, 2, 4'h6, 32'h0, 32'h0, 2);
    rdc(tmia_pkg::OFS_CCR, 32'h80);
    rdc(tmia_pkg::OFS_PEND, 32'h200);
    wr(tmia_pkg::OFS_CCR, 32'h0);
    accept(73, 2, 4'h0, 32'h0, 32'h0, 2);
  endtask
  task automatic t_m2();
    wr(tmia_pkg::OFS_MODE, 32'h2);
    rdc(tmia_pkg::OFS_MODE, 32'h2);
    wr(tmia_pkg::OFS_CCR, 32'h0);
    wr(tmia_pkg::OFS_EXR, 32'h82);
    wr(tmia_pkg::OFS_PRIO0, 32'h05050030);
    wr(tmia_pkg::OFS_EN, 32'h0052);
    pulse(16'h0052, 1'b0);
    accept(68, 2, 4'h0, 32'h0, 32'h82, 3);
    rdc(tmia_pkg::OFS_EXR, 32'h05);
    rdc(tmia_pkg::OFS_PEND, 32'h42);
    quiet();
    wr(tmia_pkg::OFS_CCR, 32'h0);
    wr(tmia_pkg::OFS_EXR, 32'h04);
    accept(70, 2, 4'h3, 32'h0, 32'h04, 3);
    rdc(tmia_pkg::OFS_EXR, 32'h05);
  endtask
  task automatic t_m2_nmi();
    wr(tmia_pkg::OFS_CCR, 32'h0);
    wr(tmia_pkg::OFS_EXR, 32'h83);
    pulse(16'h0, 1'b1);
    accept(7, 3, 4'h0, 32'h0, 32'h83, 3);
    rdc(tmia_pkg::OFS_EXR, 32'h07);
  endtask
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (2) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_m0_mask();
    t_m0_order();
    t_m2();
    t_m2_nmi();
    final_report();
  end
endmodule

// ===== tmia_core.sv
// interrupt acceptance core with fixed and level based control modes
//
// Operation
// - vectors 104-127 reserved; address is vector times four
// - two modes, 0 and 2, chosen by register
// - mode 0: fixed order, mask flag blocks maskables
// - mode 2: eight levels, three-bit mask level
// - request latched only when source enabled
// - mode 0 mask set: only nonmaskable accepted
// - mode 0: highest default-ranked request wins
// - exception starts after current instruction completes
// - mode 0: push program counter and ccr
// - mode 0: mask flag set after save
// - form vector address, fetch handler, jump
// - mode 2: highest level wins, ties fixed order
// - mode 2: level must exceed mask level
// - mode 2: push pc, ccr and exr
// - mode 2: clear trace, load accepted level
// - mode 2: nonmaskable loads mask level seven
// - priority determination three states external, two internal
module tmia_core #(
  parameter int N = 16, // maskable sources
  parameter int PC_W = 24, // program counter width
  parameter logic [N-1:0] EXT_MASK = '0, // sources that are external pins
  parameter int VEC_BASE = 64, // vector of source 0
  parameter int NMI_VEC = 7, // vector of the nonmaskable request
  parameter logic NMI_EXT = 1'b1 // nonmaskable request comes from a pin
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // interrupt sources
  input wire logic [N-1:0] src_evt_i,
  input wire logic [N-1:0] src_clr_i,
  input wire logic nmi_evt_i,
  // cpu side
  input wire logic cpu_insn_done_i,
  input wire logic [PC_W-1:0] cpu_pc_i,
  output logic stk_we_o,
  output logic [31:0] stk_data_o,
  output logic vec_rd_o,
  output logic [15:0] vec_addr_o,
  input wire logic vec_ack_i,
  input wire logic [31:0] vec_data_i,
  output logic jump_o,
  output logic [31:0] jump_addr_o,
  output logic busy_o
);
  ////////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (N < 1 || N > 16) begin : g_chk_n
    $error("source count must be 1 to 16");
  end
  if (VEC_BASE + N > tmia_pkg::VEC_RSV_LO || NMI_VEC >= VEC_BASE) begin : g_chk_v
    $error("vectors overlap the reserved range or each other");
  end
  if (PC_W > 32) begin : g_chk_pc
    $error("program counter wider than a stack word");
  end

  // vector number to table offset
  function automatic logic [15:0] vec_ofs(input logic [6:0] v);
    vec_ofs = {7'h0, v, 2'h0};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state
  tmia_pkg::tmia_state_t st_r; // acceptance sequence
  logic mode2_r; // 1 selects mode 2
  logic [N-1:0] en_r; // source enables
  logic [2:0] prio_r [N]; // programmed levels
  logic [7:0] ccr_r; // condition_code_reg
  logic [7:0] exr_r; // extended_control_reg
  logic [N-1:0] pend_r; // held requests
  logic nmi_pend_r; // held nonmaskable request
  logic [1:0] cnt_r; // priority determination countdown
  logic acc_nmi_r; // accepted request was nonmaskable
  logic [3:0] acc_idx_r; // accepted source
  logic [2:0] acc_lvl_r; // accepted level
  logic [6:0] vec_num_r; // accepted vector
  logic [31:0] hnd_r; // fetched handler address
  logic [3*N-1:0] lvl_flat; // levels for the selector
  logic win_vld;
  logic [3:0] win_idx;
  logic [2:0] win_lvl;
  logic take_m; // maskable winner passes masking
  logic take; // start acceptance this cycle
  logic [N-1:0] acc_clr; // accepted source drops out

  ////////////////////////////////////////////////////////////////////////
  // arbitration
  always_comb begin
    for (int i = 0; i < N; i++) begin
      lvl_flat[3*i +: 3] = prio_r[i];
    end
  end

  // mode 0 ignores programmed levels
  tmia_prio_sel #(.N(N)) u_sel (
    .req_i(pend_r),
    .lvl_i(lvl_flat),
    .use_lvl_i(mode2_r),
    .win_vld_o(win_vld),
    .win_idx_o(win_idx),
    .win_lvl_o(win_lvl)
  );

  // masking by mode
  always_comb begin
    if (mode2_r) begin
      take_m = win_vld && (win_lvl > exr_r[2:0]);
    end else begin
      take_m = win_vld && !ccr_r[tmia_pkg::CCR_I_BIT];
    end
    take = (st_r == tmia_pkg::ST_IDLE) && (nmi_pend_r || take_m);
    acc_clr = '0;
    if (take && !nmi_pend_r) begin
      acc_clr[win_idx] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pending latches: new event wins over any clear
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pend_r <= '0;
      nmi_pend_r <= 1'b0;
    end else begin
      // held until accepted or cleared by the source
      pend_r <= (pend_r & ~src_clr_i & ~acc_clr) | (src_evt_i & en_r);
      nmi_pend_r <= nmi_evt_i || (nmi_pend_r && !take);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // latch the accepted request
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      acc_nmi_r <= 1'b0;
      acc_idx_r <= 4'h0;
      acc_lvl_r <= 3'h0;
      vec_num_r <= 7'h0;
    end else if (take) begin
      acc_nmi_r <= nmi_pend_r;
      acc_idx_r <= win_idx;
      acc_lvl_r <= nmi_pend_r ? tmia_pkg::NMI_LEVEL : win_lvl;
      vec_num_r <= nmi_pend_r ? 7'(NMI_VEC) : 7'(VEC_BASE) + 7'(win_idx);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // acceptance sequence
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_r <= tmia_pkg::ST_IDLE;
      cnt_r <= 2'h0;
    end else begin
      case (st_r)
        tmia_pkg::ST_IDLE: begin
          if (take) begin
            st_r <= tmia_pkg::ST_PRIO;
            // external sources need one more state
            if (nmi_pend_r ? NMI_EXT : EXT_MASK[win_idx]) begin
              cnt_r <= tmia_pkg::PRIO_EXT_CYC - 2'h1;
            end else begin
              cnt_r <= tmia_pkg::PRIO_INT_CYC - 2'h1;
            end
          end
        end
        tmia_pkg::ST_PRIO: begin
          cnt_r <= cnt_r - 2'h1;
          if (cnt_r == 2'h0) begin
            st_r <= tmia_pkg::ST_WAIT;
          end
        end
        tmia_pkg::ST_WAIT: begin
          // never abort the running instruction
          if (cpu_insn_done_i) begin
            st_r <= tmia_pkg::ST_PPC;
          end
        end
        tmia_pkg::ST_PPC: begin
          st_r <= tmia_pkg::ST_PCCR;
        end
        tmia_pkg::ST_PCCR: begin
          st_r <= mode2_r ? tmia_pkg::ST_PEXR : tmia_pkg::ST_VREQ;
        end
        tmia_pkg::ST_PEXR: begin
          st_r <= tmia_pkg::ST_VREQ;
        end
        tmia_pkg::ST_VREQ: begin
          st_r <= tmia_pkg::ST_VWAIT;
        end
        tmia_pkg::ST_VWAIT: begin
          if (vec_ack_i) begin
            st_r <= tmia_pkg::ST_JUMP;
          end
        end
        tmia_pkg::ST_JUMP: begin
          st_r <= tmia_pkg::ST_IDLE;
        end
        default: begin
          st_r <= tmia_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // handler address capture
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      hnd_r <= 32'h0;
    end else if (st_r == tmia_pkg::ST_VWAIT && vec_ack_i) begin
      hnd_r <= vec_data_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cpu side outputs
  always_comb begin
    stk_we_o = (st_r == tmia_pkg::ST_PPC) || (st_r == tmia_pkg::ST_PCCR) ||
               (st_r == tmia_pkg::ST_PEXR);
    vec_rd_o = (st_r == tmia_pkg::ST_VREQ);
    jump_o = (st_r == tmia_pkg::ST_JUMP);
    busy_o = (st_r != tmia_pkg::ST_IDLE);
  end

  // stack word and vector offset from flops
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      stk_data_o <= 32'h0;
    end else if (st_r == tmia_pkg::ST_WAIT) begin
      stk_data_o <= 32'(cpu_pc_i);
    end else if (st_r == tmia_pkg::ST_PPC) begin
      stk_data_o <= {24'h0, ccr_r};
    end else if (st_r == tmia_pkg::ST_PCCR) begin
      stk_data_o <= {24'h0, exr_r};
    end
  end

  assign vec_addr_o = vec_ofs(vec_num_r);
  assign jump_addr_o = hnd_r;

  ////////////////////////////////////////////////////////////////////////
  // software registers: mode, enables, levels
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      mode2_r <= 1'b0;
      en_r <= '0;
      for (int i = 0; i < N; i++) begin
        prio_r[i] <= 3'h0;
      end
    end else if (reg_wr_i) begin
      if (reg_addr_i == tmia_pkg::OFS_MODE) begin
        // only values 0 and 2 in bits 1:0 select a mode
        if (reg_wdata_i[1:0] == tmia_pkg::MODE_0 || reg_wdata_i[1:0] == tmia_pkg::MODE_2) begin
          mode2_r <= reg_wdata_i[tmia_pkg::MODE_BIT];
        end
      end
      if (reg_addr_i == tmia_pkg::OFS_EN) begin
        en_r <= reg_wdata_i[N-1:0];
      end
      for (int i = 0; i < N; i++) begin
        if (reg_addr_i == (i < 8 ? tmia_pkg::OFS_PRIO0 : tmia_pkg::OFS_PRIO1)) begin
          prio_r[i] <= reg_wdata_i[tmia_pkg::PRIO_FLD_W*(i%8) +: 3];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ccr and exr: sequence updates win over software writes
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ccr_r <= tmia_pkg::CCR_RST;
      exr_r <= tmia_pkg::EXR_RST;
    end else if (st_r == tmia_pkg::ST_VREQ) begin
      // context already on the stack
      if (mode2_r) begin
        exr_r[tmia_pkg::EXR_T_BIT] <= 1'b0;
        exr_r[2:0] <= acc_lvl_r;
      end else begin
        ccr_r[tmia_pkg::CCR_I_BIT] <= 1'b1;
      end
    end else if (reg_wr_i && reg_addr_i == tmia_pkg::OFS_CCR) begin
      ccr_r <= reg_wdata_i[7:0];
    end else if (reg_wr_i && reg_addr_i == tmia_pkg::OFS_EXR) begin
      exr_r <= {reg_wdata_i[7], 4'h0, reg_wdata_i[2:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= 32'h0;
      case (reg_addr_i)
        tmia_pkg::OFS_MODE: reg_rdata_o <= {30'h0, mode2_r, 1'b0};
        tmia_pkg::OFS_EN: reg_rdata_o <= 32'(en_r);
        tmia_pkg::OFS_CCR: reg_rdata_o <= {24'h0, ccr_r};
        tmia_pkg::OFS_EXR: reg_rdata_o <= {24'h0, exr_r};
        tmia_pkg::OFS_PEND: reg_rdata_o <= {nmi_pend_r, 15'h0, 16'(pend_r)};
        tmia_pkg::OFS_VEC: reg_rdata_o <= {25'h0, vec_num_r};
        default: begin
          for (int i = 0; i < N; i++) begin
            if (reg_addr_i == (i < 8 ? tmia_pkg::OFS_PRIO0 : tmia_pkg::OFS_PRIO1)) begin
              reg_rdata_o[tmia_pkg::PRIO_FLD_W*(i%8) +: 3] <= prio_r[i];
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  logic [N-1:0] below_win; // sources ranked above the winner
  assign below_win = (N'(1) << win_idx) - N'(1);

  sequence s_push_pc;
    stk_we_o && stk_data_o == 32'($past(cpu_pc_i));
  endsequence
  sequence s_push_ccr;
    stk_we_o && stk_data_o[7:0] == ccr_r;
  endsequence

  vec_addr_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    vec_rd_o |-> vec_addr_o == 16'(vec_num_r) * 16'h4 && vec_num_r < 7'(tmia_pkg::VEC_RSV_LO))
    else $error("vector address wrong or reserved");
  mask_flag_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    st_r == tmia_pkg::ST_IDLE && !mode2_r && ccr_r[7] && !nmi_pend_r |=> !busy_o)
    else $error("masked request accepted in mode 0");
  fixed_order_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    take && !nmi_pend_r && !mode2_r |-> (pend_r & below_win) == '0)
    else $error("lower ranked request won in mode 0");
  insn_wait_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    st_r == tmia_pkg::ST_WAIT && !cpu_insn_done_i |=> !stk_we_o)
    else $error("stacking before instruction end");
  ctx_save_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    st_r == tmia_pkg::ST_WAIT && cpu_insn_done_i |=> s_push_pc ##1 s_push_ccr)
    else $error("context save order wrong");
  mask_set_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    st_r == tmia_pkg::ST_VREQ && !mode2_r |=> ccr_r[7])
    else $error("mask flag not set after save");
  level_gate_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    take && mode2_r && !nmi_pend_r |-> win_lvl > exr_r[2:0])
    else $error("level not above mask accepted");
  exr_push_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    st_r == tmia_pkg::ST_PCCR && mode2_r |=> stk_we_o && stk_data_o[7:0] == $past(exr_r))
    else $error("extended register not stacked");
  exr_load_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    jump_o && mode2_r |-> !exr_r[7] && exr_r[2:0] == (acc_nmi_r ? 3'h7 : acc_lvl_r))
    else $error("mask level or trace wrong at jump");
  prio_ext_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    take && (nmi_pend_r ? NMI_EXT : EXT_MASK[win_idx]) |=>
      st_r == tmia_pkg::ST_PRIO [*3] ##1 st_r == tmia_pkg::ST_WAIT)
    else $error("external determination not three states");
  hold_pend_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    pend_r[3] && !src_clr_i[3] && !acc_clr[3] |=> pend_r[3])
    else $error("blocked request dropped");
  jump_tgt_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    st_r == tmia_pkg::ST_VWAIT && vec_ack_i |=> jump_o && jump_addr_o == $past(vec_data_i))
    else $error("jump target not the fetched handler");
endmodule

// ===== tmia_cpu_model.sv
// cpu side stand-in: ends instructions late and answers vector fetches
module tmia_cpu_model #(
  parameter int ACK_DLY = 2 // cycles from fetch latch to answer, one more from the fetch strobe
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // from the core, stall length from the bench
  input wire logic busy_i,
  input wire logic vec_rd_i,
  input wire logic [15:0] vec_addr_i,
  input wire logic [3:0] done_dly_i,
  // to the core
  output logic insn_done_o,
  output logic vec_ack_o,
  output logic [31:0] vec_data_o
);
  logic [3:0] bcnt_r; // busy cycles so far
  logic [3:0] acnt_r; // cycles since fetch
  logic apend_r; // fetch outstanding
  logic [15:0] addr_r; // fetched address
  ////////////////////////////////////////////////////////////////
  // count busy cycles, saturating
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || !busy_i) begin
      bcnt_r <= '0;
    end else if (bcnt_r != 4'hf) begin
      bcnt_r <= bcnt_r + 4'h1;
    end
  end
  // instruction ends only after the chosen stall
  assign insn_done_o = busy_i && (bcnt_r >= done_dly_i);
  ////////////////////////////////////////////////////////////////
  // vector fetch answered after a fixed delay
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || vec_ack_o) begin
      apend_r <= 1'b0;
      acnt_r <= '0;
    end else if (vec_rd_i) begin
      apend_r <= 1'b1;
      addr_r <= vec_addr_i;
    end else if (apend_r) begin
      acnt_r <= acnt_r + 4'h1;
    end
  end
  assign vec_ack_o = apend_r && (acnt_r == ACK_DLY[3:0]);
  // handler word only while answering, scrambled otherwise
  assign vec_data_o = vec_ack_o ? {16'h5a00, addr_r} : {16'ha5ff, ~addr_r};
endmodule

// ===== tmia_pkg.sv
// shared constants and state type for the two mode interrupt arbiter
package tmia_pkg;
  // register offsets, byte addresses on the plain register port
  localparam logic [7:0] OFS_MODE = 8'h00; // control_mode_select
  localparam logic [7:0] OFS_EN = 8'h04; // per-source enable bits
  localparam logic [7:0] OFS_PRIO0 = 8'h08; // priority_level_regs sources 0..7
  localparam logic [7:0] OFS_PRIO1 = 8'h0c; // priority_level_regs sources 8..15
  localparam logic [7:0] OFS_CCR = 8'h10; // condition_code_reg
  localparam logic [7:0] OFS_EXR = 8'h14; // extended_control_reg
  localparam logic [7:0] OFS_PEND = 8'h18; // pending requests, read only
  localparam logic [7:0] OFS_VEC = 8'h1c; // last accepted vector, read only
  // field positions
  localparam int MODE_BIT = 1; // mode value 2 has bit 1 set
  localparam int CCR_I_BIT = 7; // master mask flag
  localparam int EXR_T_BIT = 7; // trace flag
  localparam int PRIO_FLD_W = 4; // nibble per source in a priority word
  // reset values
  localparam logic [7:0] CCR_RST = 8'h80; // mask flag set out of reset
  localparam logic [7:0] EXR_RST = 8'h07; // mask level 7 out of reset
  // mode encodings
  localparam logic [1:0] MODE_0 = 2'h0;
  localparam logic [1:0] MODE_2 = 2'h2;
  // vectors
  localparam int VEC_RSV_LO = 104; // first reserved vector, no source
  localparam int VEC_W = 7; // vector number width
  localparam logic [2:0] NMI_LEVEL = 3'h7; // mask level after nmi in mode 2
  // priority determination length in cpu states
  localparam logic [1:0] PRIO_EXT_CYC = 2'h3;
  localparam logic [1:0] PRIO_INT_CYC = 2'h2;
  // acceptance sequence, gray coded from idle to jump along the mode 2 path
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_PRIO = 4'h1,
    ST_WAIT = 4'h3,
    ST_PPC = 4'h2,
    ST_PCCR = 4'h6,
    ST_PEXR = 4'h7,
    ST_VREQ = 4'h5,
    ST_VWAIT = 4'h4,
    ST_JUMP = 4'hc
  } tmia_state_t;
endpackage

// ===== tmia_prio_sel.sv
// picks the winning request by programmed level, ties to the lowest index
module tmia_prio_sel #(
  parameter int N = 16
) (
  // requests and levels
  input wire logic [N-1:0] req_i,
  input wire logic [3*N-1:0] lvl_i,
  input wire logic use_lvl_i,
  // winner
  output logic win_vld_o,
  output logic [3:0] win_idx_o,
  output logic [2:0] win_lvl_o
);
  // a four-bit winner index serves at most sixteen requests
  if (N < 1 || N > 16) begin : g_chk_n
    $error("request count must be 1 to 16");
  end

  ////////////////////////////////////////////////////////////////////////
  // scan from high index down so the lowest index wins equal levels
  always_comb begin
    logic [2:0] l;
    l = 3'h0;
    win_vld_o = 1'b0;
    win_idx_o = 4'h0;
    win_lvl_o = 3'h0;
    for (int i = N - 1; i >= 0; i--) begin
      // fixed order ignores programmed levels
      l = use_lvl_i ? lvl_i[3*i +: 3] : 3'h0;
      if (req_i[i] && (!win_vld_o || l >= win_lvl_o)) begin
        win_vld_o = 1'b1;
        win_idx_o = 4'(i);
        win_lvl_o = l;
      end
    end
  end
endmodule
